// [hw/idx_decoder_consts.vh]
`ifndef IDX_DECODER_CONSTS_VH
`define IDX_DECODER_CONSTS_VH
// Addressing modes
`define MODE_INHERENT     3'h0
`define MODE_IMMEDIATE    3'h1
`define MODE_DIRECT       3'h2
`define MODE_EXTENDED     3'h3
`define MODE_RELATIVE     3'h4
`define MODE_INDEXED      3'h5
// Base register field codes
`define BASE_X            2'h0
`define BASE_Y            2'h1
`define BASE_SP           2'h2
`define BASE_PC           2'h3
// Page two prefix byte
`define PAGE2_PREFIX      8'h18
// Accumulator offset selectors
`define ACC_SEL_A         2'h0
`define ACC_SEL_B         2'h1
`define ACC_SEL_D         2'h2
`define ACC_SEL_D_IND     2'h3
// Condition flag bit positions
`define CCR_STOP_DIS      7
`define CCR_XMASK         6
`define CCR_HALF          5
`define CCR_IMASK         4
`define CCR_NEG           3
`define CCR_ZERO          2
`define CCR_OVF           1
`define CCR_CARRY         0
// Reset values
`define CCR_RESET         8'hD0
`define WORD_RESET        16'h0000
`define BYTE_RESET        8'h00
`endif

// [hw/index_postbyte_decode.v]
`timescale 1ns/100ps
`include "idx_decoder_consts.vh"
// Pure decode of an indexed postbyte plus its extension bytes
module index_postbyte_decode (
   input  wire [7:0]  postbyte_i,
   input  wire [7:0]  ext1_i,
   input  wire [7:0]  ext2_i,
   input  wire [15:0] base_i,
   input  wire [7:0]  acc_a_i,
   input  wire [7:0]  acc_b_i,
   output reg  [15:0] ea_o,
   output reg  [15:0] base_new_o,
   output reg         base_write_o,
   output reg         indirect_o,
   output reg  [1:0]  ext_count_o,
   output reg         illegal_o
);
   reg [15:0] step;
   always @* begin
      ea_o         = base_i;
      base_new_o   = base_i;
      base_write_o = 1'b0;
      indirect_o   = 1'b0;
      ext_count_o  = 2'h0;
      illegal_o    = 1'b0;
      step         = 16'h0000;
      if (!postbyte_i[5]) begin
         // Five bit signed constant
         ea_o = base_i + {{11{postbyte_i[4]}}, postbyte_i[4:0]};
      end else if (postbyte_i[7:5] != 3'h7) begin
         // Auto inc/dec; magnitude 1..8, negative codes mean decrement
         step       = postbyte_i[3] ? {12'hFFF, postbyte_i[3:0]} : ({12'h000, postbyte_i[3:0]} + 16'h0001);
         base_new_o = base_i + step;
         ea_o       = postbyte_i[4] ? base_i : base_new_o;
         base_write_o = 1'b1;
      end else if (!postbyte_i[2]) begin
         if (!postbyte_i[1]) begin
            ea_o        = base_i + {{8{postbyte_i[0]}}, ext1_i};
            ext_count_o = 2'h1;
         end else begin
            ea_o        = base_i + {ext1_i, ext2_i};
            ext_count_o = 2'h2;
            indirect_o  = postbyte_i[0];
         end
      end else begin
         case (postbyte_i[1:0])
            `ACC_SEL_A: ea_o = base_i + {8'h00, acc_a_i};
            `ACC_SEL_B: ea_o = base_i + {8'h00, acc_b_i};
            default: begin
               ea_o       = base_i + {acc_a_i, acc_b_i};
               indirect_o = (postbyte_i[1:0] == `ACC_SEL_D_IND);
            end
         endcase
      end
      // The program counter may not be auto-modified
      if (base_write_o && (postbyte_i[7:6] == `BASE_PC)) begin
         illegal_o    = 1'b1;
         base_write_o = 1'b0;
      end
   end
endmodule // index_postbyte_decode

// [hw/cpu_indexed_address_decoder.v]
// Summary of operation
// - Two 8-bit accumulators, paired as 16-bit double accumulator for some instructions.
// - Indexed address is base plus 5, 9, 16-bit constant or accumulator.
// - Stack pointer names last used location, saves context, serves as indexed base.
// - 16-bit program counter holds next address; no auto inc/dec on it.
// - Flag register holds five status flags, two masks, one stop disable bit.
// - Half carry for decimal math only; N Z V C reflect prior result.
// - Words are two bytes, high byte first, at any byte address.
// - Direct mode uses one byte as low address, high byte zero.
// - Extended carries full 16-bit address; immediate data comes from instruction stream.
// - Relative target is program counter plus 8 or 16-bit offset.
// - Postbyte alone selects the indexed form; zero to two extension bytes follow.
// - Pattern rr0nnnn adds 5-bit signed offset -16..+15 to base.
// - Pattern 111rr0zs: z=0 nine bit signed, z=1 sixteen bit offset.
// - Pattern 111rr011 uses base plus 16-bit offset as pointer location.
// - Pattern rr1pnnnn auto pre/post inc/dec X, Y, SP by 1..8.
// - Pattern 111rr1aa adds unsigned A, B or D to base.
// - Pattern 111rr111 uses base plus D as pointer location.
// - Opcodes are 8 bits; prefix 18 hex selects second opcode page.
// - Bytes after opcode are postbytes or extension bytes.
`timescale 1ns/100ps
`include "idx_decoder_consts.vh"
module cpu_indexed_address_decoder (
   input  wire        CLK_I,
   input  wire        RST_N_I,
   // Instruction byte stream, one byte per strobe
   input  wire        BYTE_VALID_I,
   input  wire [7:0]  BYTE_I,
   output reg         BYTE_READY_O,
   // Opcode classification from the opcode map
   input  wire        OPC_VALID_I,
   input  wire [2:0]  OPC_MODE_I,
   input  wire        OPC_WIDE_I,
   input  wire        OPC_HAS_POSTBYTE_I,
   // Memory read data for indirect pointer
   output reg         PTR_REQ_O,
   output reg  [15:0] PTR_ADDR_O,
   input  wire        PTR_VALID_I,
   input  wire [15:0] PTR_DATA_I,
   // Register writes from the execution unit
   input  wire        WR_A_I,
   input  wire        WR_B_I,
   input  wire        WR_D_I,
   input  wire        WR_X_I,
   input  wire        WR_Y_I,
   input  wire        WR_SP_I,
   input  wire        WR_PC_I,
   input  wire [15:0] WR_DATA_I,
   input  wire        FLAGS_WE_I,
   input  wire [7:0]  FLAGS_I,
   // Decoded results
   output reg         OPCODE_VALID_O,
   output reg  [7:0]  OPCODE_O,
   output reg         PAGE2_O,
   output reg         EA_VALID_O,
   output reg  [15:0] EA_O,
   output reg  [2:0]  MODE_O,
   output reg  [15:0] IMM_O,
   output reg         ILLEGAL_O,
   output reg  [15:0] ACC_D_O,
   output reg  [15:0] INDEX_X_O,
   output reg  [15:0] INDEX_Y_O,
   output reg  [15:0] STACK_PTR_O,
   output reg  [15:0] PC_O,
   output reg  [7:0]  CONDITION_FLAGS_O
);
   ////////////////////////////////////////////////////////////////////////
   localparam [6:0] ST_OPCODE  = 7'h01;
   localparam [6:0] ST_CLASS   = 7'h02;
   localparam [6:0] ST_POST    = 7'h04;
   localparam [6:0] ST_EXT1    = 7'h08;
   localparam [6:0] ST_EXT2    = 7'h10;
   localparam [6:0] ST_RESOLVE = 7'h20;
   localparam [6:0] ST_PTR     = 7'h40;

   reg [6:0]  state;
   reg [7:0]  acc_a;
   reg [7:0]  acc_b;
   reg [15:0] index_x;
   reg [15:0] index_y;
   reg [15:0] stack_ptr;
   reg [15:0] prog_ctr;
   reg [7:0]  condition_flags_reg;
   reg [7:0]  index_postbyte;
   reg [7:0]  ext1;
   reg [7:0]  ext2;
   reg [1:0]  ext_need;
   reg        page2;
   reg [2:0]  mode;
   reg        wide;
   reg [15:0] base;
   wire [15:0] idx_ea;
   wire [15:0] idx_base_new;
   wire        idx_base_write;
   wire        idx_indirect;
   wire        idx_illegal;
   wire        take = BYTE_VALID_I & BYTE_READY_O;
   // Long forms (111 prefix) carry the base field in bits 4:3, short ones in 7:6
   wire [1:0]  base_sel = (index_postbyte[7:5] == 3'h7) ? index_postbyte[4:3] : index_postbyte[7:6];

   // Base selection by field code
   always @* begin
      case (base_sel)
         `BASE_X:  base = index_x;
         `BASE_Y:  base = index_y;
         `BASE_SP: base = stack_ptr;
         default:  base = prog_ctr;
      endcase
   end

   index_postbyte_decode u_decode (
      .postbyte_i   (index_postbyte),
      .ext1_i       (ext1),
      .ext2_i       (ext2),
      .base_i       (base),
      .acc_a_i      (acc_a),
      .acc_b_i      (acc_b),
      .ea_o         (idx_ea),
      .base_new_o   (idx_base_new),
      .base_write_o (idx_base_write),
      .indirect_o   (idx_indirect),
      .ext_count_o  (),
      .illegal_o    (idx_illegal)
   );

   // Extension bytes needed: for indexed forms known only after the postbyte arrives, otherwise from the opcode class
   wire [1:0] post_need = (!BYTE_I[5] || BYTE_I[7:5] != 3'h7) ? 2'h0 :
                          (BYTE_I[2] ? 2'h0 : (BYTE_I[1] ? 2'h2 : 2'h1));
   wire [1:0] plain_need = (OPC_MODE_I == `MODE_INHERENT) ? 2'h0 :
                           (OPC_MODE_I == `MODE_DIRECT) ? 2'h1 :
                           (OPC_MODE_I == `MODE_EXTENDED) ? 2'h2 :
                           (OPC_WIDE_I ? 2'h2 : 2'h1);

   ////////////////////////////////////////////////////////////////////////
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state               <= ST_OPCODE;
         acc_a               <= `BYTE_RESET;
         acc_b               <= `BYTE_RESET;
         index_x             <= `WORD_RESET;
         index_y             <= `WORD_RESET;
         stack_ptr           <= `WORD_RESET;
         prog_ctr            <= `WORD_RESET;
         condition_flags_reg <= `CCR_RESET;
         index_postbyte      <= `BYTE_RESET;
         ext1                <= `BYTE_RESET;
         ext2                <= `BYTE_RESET;
         ext_need            <= 2'h0;
         page2               <= 1'b0;
         mode                <= `MODE_INHERENT;
         wide                <= 1'b0;
         BYTE_READY_O        <= 1'b1;
         OPCODE_VALID_O      <= 1'b0;
         OPCODE_O            <= `BYTE_RESET;
         PAGE2_O             <= 1'b0;
         EA_VALID_O          <= 1'b0;
         EA_O                <= `WORD_RESET;
         MODE_O              <= `MODE_INHERENT;
         IMM_O               <= `WORD_RESET;
         ILLEGAL_O           <= 1'b0;
         PTR_REQ_O           <= 1'b0;
         PTR_ADDR_O          <= `WORD_RESET;
      end else begin
         OPCODE_VALID_O <= 1'b0;
         EA_VALID_O     <= 1'b0;
         ILLEGAL_O      <= 1'b0;
         if (take)
            prog_ctr <= prog_ctr + 16'h0001;
         case (state)
            ST_OPCODE: begin
               if (take) begin
                  if (BYTE_I == `PAGE2_PREFIX && !page2) begin
                     page2 <= 1'b1;
                  end else begin
                     OPCODE_O       <= BYTE_I;
                     PAGE2_O        <= page2;
                     OPCODE_VALID_O <= 1'b1;
                     page2          <= 1'b0;
                     BYTE_READY_O   <= 1'b0;
                     state          <= ST_CLASS;
                  end
               end
            end
            ST_CLASS: begin
               // Wait for the opcode map's classification
               if (OPC_VALID_I) begin
                  mode         <= OPC_MODE_I;
                  wide         <= OPC_WIDE_I;
                  BYTE_READY_O <= 1'b1;
                  ext1         <= `BYTE_RESET;
                  ext2         <= `BYTE_RESET;
                  if (OPC_HAS_POSTBYTE_I) begin
                     state <= ST_POST;
                  end else if (plain_need == 2'h0) begin
                     ext_need <= 2'h0;
                     state    <= ST_RESOLVE;
                     BYTE_READY_O <= 1'b0;
                  end else begin
                     ext_need <= plain_need;
                     state    <= ST_EXT1;
                  end
               end
            end
            ST_POST: begin
               if (take) begin
                  index_postbyte <= BYTE_I;
                  mode           <= `MODE_INDEXED;
                  ext_need       <= post_need;
                  if (post_need == 2'h0) begin
                     BYTE_READY_O <= 1'b0;
                     state        <= ST_RESOLVE;
                  end else begin
                     state <= ST_EXT1;
                  end
               end
            end
            ST_EXT1: begin
               if (take) begin
                  if (ext_need == 2'h1) begin
                     ext1         <= BYTE_I;
                     BYTE_READY_O <= 1'b0;
                     state        <= ST_RESOLVE;
                  end else begin
                     ext1  <= BYTE_I;
                     state <= ST_EXT2;
                  end
               end
            end
            ST_EXT2: begin
               if (take) begin
                  ext2         <= BYTE_I;
                  BYTE_READY_O <= 1'b0;
                  state        <= ST_RESOLVE;
               end
            end
            ST_RESOLVE: begin
               MODE_O <= mode;
               state  <= ST_OPCODE;
               BYTE_READY_O <= 1'b1;
               case (mode)
                  `MODE_DIRECT: begin
                     EA_O       <= {8'h00, ext1};
                     EA_VALID_O <= 1'b1;
                  end
                  `MODE_EXTENDED: begin
                     EA_O       <= {ext1, ext2};
                     EA_VALID_O <= 1'b1;
                  end
                  `MODE_IMMEDIATE: begin
                     IMM_O <= wide ? {ext1, ext2} : {8'h00, ext1};
                  end
                  `MODE_RELATIVE: begin
                     // Program counter already points past the offset
                     EA_O       <= prog_ctr + (wide ? {ext1, ext2} : {{8{ext1[7]}}, ext1});
                     EA_VALID_O <= 1'b1;
                  end
                  `MODE_INDEXED: begin
                     ILLEGAL_O <= idx_illegal;
                     if (idx_base_write) begin
                        case (index_postbyte[7:6])
                           `BASE_X: index_x   <= idx_base_new;
                           `BASE_Y: index_y   <= idx_base_new;
                           default: stack_ptr <= idx_base_new;
                        endcase
                     end
                     if (idx_indirect) begin
                        PTR_REQ_O    <= 1'b1;
                        PTR_ADDR_O   <= idx_ea;
                        BYTE_READY_O <= 1'b0;
                        state        <= ST_PTR;
                     end else begin
                        EA_O       <= idx_ea;
                        EA_VALID_O <= ~idx_illegal;
                     end
                  end
                  default: begin
                     EA_O <= `WORD_RESET;
                  end
               endcase
            end
            ST_PTR: begin
               // Pointer word fetched high byte first by the memory side
               if (PTR_VALID_I) begin
                  PTR_REQ_O    <= 1'b0;
                  EA_O         <= PTR_DATA_I;
                  EA_VALID_O   <= 1'b1;
                  BYTE_READY_O <= 1'b1;
                  state        <= ST_OPCODE;
               end
            end
            default: state <= ST_OPCODE;
         endcase
         // Execution-unit writes take priority over decode side effects
         if (WR_A_I) acc_a <= WR_DATA_I[7:0];
         if (WR_B_I) acc_b <= WR_DATA_I[7:0];
         if (WR_D_I) begin
            acc_a <= WR_DATA_I[15:8];
            acc_b <= WR_DATA_I[7:0];
         end
         if (WR_X_I) index_x <= WR_DATA_I;
         if (WR_Y_I) index_y <= WR_DATA_I;
         if (WR_SP_I) stack_ptr <= WR_DATA_I;
         if (WR_PC_I) prog_ctr <= WR_DATA_I;
         if (FLAGS_WE_I) condition_flags_reg <= FLAGS_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register mirrors, one cycle behind the live state
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ACC_D_O           <= `WORD_RESET;
         INDEX_X_O         <= `WORD_RESET;
         INDEX_Y_O         <= `WORD_RESET;
         STACK_PTR_O       <= `WORD_RESET;
         PC_O              <= `WORD_RESET;
         CONDITION_FLAGS_O <= `CCR_RESET;
      end else begin
         ACC_D_O           <= {acc_a, acc_b};
         INDEX_X_O         <= index_x;
         INDEX_Y_O         <= index_y;
         STACK_PTR_O       <= stack_ptr;
         PC_O              <= prog_ctr;
         CONDITION_FLAGS_O <= condition_flags_reg;
      end
   end
endmodule // cpu_indexed_address_decoder

// [tb/cpu_indexed_address_decoder_assertions.sv]
`timescale 1ns/100ps
`include "idx_decoder_consts.vh"
module cpu_indexed_address_decoder_checker (
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        BYTE_VALID_I,
   input wire logic [7:0]  BYTE_I,
   input wire logic        BYTE_READY_O,
   input wire logic        PTR_REQ_O,
   input wire logic [15:0] PTR_ADDR_O,
   input wire logic        PTR_VALID_I,
   input wire logic [15:0] PTR_DATA_I,
   input wire logic        WR_D_I,
   input wire logic        WR_PC_I,
   input wire logic [15:0] WR_DATA_I,
   input wire logic        FLAGS_WE_I,
   input wire logic [7:0]  FLAGS_I,
   input wire logic        OPCODE_VALID_O,
   input wire logic [7:0]  OPCODE_O,
   input wire logic        EA_VALID_O,
   input wire logic [15:0] EA_O,
   input wire logic [2:0]  MODE_O,
   input wire logic [15:0] ACC_D_O,
   input wire logic [15:0] PC_O,
   input wire logic [7:0]  CONDITION_FLAGS_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////////////
   a_reset_state: assert property ($rose(RST_N_I) |-> BYTE_READY_O && CONDITION_FLAGS_O == 8'hD0
      && !EA_VALID_O && !OPCODE_VALID_O) else $error("Reset state wrong");
   a_opcode_byte: assert property (OPCODE_VALID_O |-> OPCODE_O == $past(BYTE_I)
      && $past(BYTE_VALID_I && BYTE_READY_O)) else $error("Opcode not the taken byte");
   a_class_refuse: assert property (OPCODE_VALID_O |-> !BYTE_READY_O ##1 !OPCODE_VALID_O)
      else $error("Byte accepted during classification");
   a_ea_pulse: assert property (EA_VALID_O |=> !EA_VALID_O) else $error("Address pulse too long");
   // Pointer address must not wander while memory is still fetching
   a_ptr_hold: assert property (PTR_REQ_O && !PTR_VALID_I |=> PTR_REQ_O && $stable(PTR_ADDR_O)
      && !BYTE_READY_O) else $error("Pointer request dropped");
   a_ptr_result: assert property (PTR_REQ_O && PTR_VALID_I |=> EA_VALID_O
      && EA_O == $past(PTR_DATA_I)) else $error("Indirect address not the pointer");
   a_direct_page: assert property (EA_VALID_O && MODE_O == `MODE_DIRECT |-> EA_O[15:8] == 8'h00)
      else $error("Direct address high byte set");
   a_flags_mirror: assert property (FLAGS_WE_I |-> ##2 CONDITION_FLAGS_O == $past(FLAGS_I, 2))
      else $error("Flag write lost");
   a_dacc_mirror: assert property (WR_D_I |-> ##2 ACC_D_O == $past(WR_DATA_I, 2))
      else $error("Double accumulator write lost");
   a_pc_step: assert property (BYTE_VALID_I && BYTE_READY_O && !WR_PC_I |-> ##2 PC_O == $past(PC_O) + 16'h0001)
      else $error("Counter did not step on byte");
endmodule // cpu_indexed_address_decoder_checker

// [tb/cpu_indexed_address_decoder_bench.sv]
`timescale 1ns/100ps
`include "idx_decoder_consts.vh"
module cpu_indexed_address_decoder_bench;
   logic        CLK_I, RST_N_I, BYTE_VALID_I, OPC_VALID_I, OPC_WIDE_I, OPC_HAS_POSTBYTE_I, PTR_VALID_I;
   logic        WR_A_I, WR_B_I, WR_D_I, WR_X_I, WR_Y_I, WR_SP_I, WR_PC_I, FLAGS_WE_I;
   logic        BYTE_READY_O, PTR_REQ_O, OPCODE_VALID_O, PAGE2_O, EA_VALID_O, ILLEGAL_O;
   logic [7:0]  BYTE_I, FLAGS_I, OPCODE_O, CONDITION_FLAGS_O;
   logic [2:0]  OPC_MODE_I, MODE_O;
   logic [15:0] PTR_DATA_I, WR_DATA_I, PTR_ADDR_O, EA_O, IMM_O, ACC_D_O;
   logic [15:0] INDEX_X_O, INDEX_Y_O, STACK_PTR_O, PC_O, pc_exp;
   int          n_fail, checks;
   // Index table: base X=1000, Y=2000, SP=3000, D=8005; auto forms last since they move bases
   logic [7:0]  pb_tab [14] = '{8'h10, 8'h4F, 8'h80, 8'hE1, 8'hEA, 8'hF4, 8'hE5, 8'hEE, 8'hE3, 8'hEF,
                                8'hE8, 8'h22, 8'h7F, 8'hA8};
   int          nx_tab [14] = '{0, 0, 0, 1, 2, 0, 0, 0, 2, 0, 1, 0, 0, 0};
   logic [15:0] ex_tab [14] = '{0, 0, 0, 16'h0000, 16'h1234, 0, 0, 0, 16'h0010, 0, 16'h007F, 0, 0, 0};
   logic [15:0] ea_tab [14] = '{16'h0FF0, 16'h200F, 16'h3000, 16'h0F00, 16'h3234, 16'h3080, 16'h1005,
                                16'hA005, 16'hCAFE, 16'h5A5A, 16'h207F, 16'h1003, 16'h2000, 16'h2FF8};
   logic [15:0] pa_tab [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'h1010, 16'hA005, 0, 0, 0, 0};
   ////////////////////////////////////////////////////////////////////////////////
   cpu_indexed_address_decoder dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .BYTE_VALID_I(BYTE_VALID_I),
      .BYTE_I(BYTE_I), .BYTE_READY_O(BYTE_READY_O), .OPC_VALID_I(OPC_VALID_I), .OPC_MODE_I(OPC_MODE_I),
      .OPC_WIDE_I(OPC_WIDE_I), .OPC_HAS_POSTBYTE_I(OPC_HAS_POSTBYTE_I), .PTR_REQ_O(PTR_REQ_O),
      .PTR_ADDR_O(PTR_ADDR_O), .PTR_VALID_I(PTR_VALID_I), .PTR_DATA_I(PTR_DATA_I), .WR_A_I(WR_A_I),
      .WR_B_I(WR_B_I), .WR_D_I(WR_D_I), .WR_X_I(WR_X_I), .WR_Y_I(WR_Y_I), .WR_SP_I(WR_SP_I),
      .WR_PC_I(WR_PC_I), .WR_DATA_I(WR_DATA_I), .FLAGS_WE_I(FLAGS_WE_I), .FLAGS_I(FLAGS_I),
      .OPCODE_VALID_O(OPCODE_VALID_O), .OPCODE_O(OPCODE_O), .PAGE2_O(PAGE2_O), .EA_VALID_O(EA_VALID_O),
      .EA_O(EA_O), .MODE_O(MODE_O), .IMM_O(IMM_O), .ILLEGAL_O(ILLEGAL_O), .ACC_D_O(ACC_D_O),
      .INDEX_X_O(INDEX_X_O), .INDEX_Y_O(INDEX_Y_O), .STACK_PTR_O(STACK_PTR_O), .PC_O(PC_O),
      .CONDITION_FLAGS_O(CONDITION_FLAGS_O));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task end_sim;
      $display("Checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Strobe order A,B,D,X,Y,SP,PC; mirrors lag one edge so wait two falling edges
   task wr(input logic [6:0] sel, input logic [15:0] d);
      {WR_A_I, WR_B_I, WR_D_I, WR_X_I, WR_Y_I, WR_SP_I, WR_PC_I} = sel;
      WR_DATA_I = d;
      @(negedge CLK_I);
      {WR_A_I, WR_B_I, WR_D_I, WR_X_I, WR_Y_I, WR_SP_I, WR_PC_I} = 7'h00;
      @(negedge CLK_I);
   endtask
   // Valid stays up after a byte so bytes run back to back; callers drop it
   task send(input logic [7:0] b);
      int n;
      n = 0;
      while (BYTE_READY_O !== 1'b1 && n < 20) begin
         BYTE_VALID_I = 1'b0;
         @(negedge CLK_I);
         n++;
      end
      BYTE_VALID_I = 1'b1;
      BYTE_I = b;
      @(negedge CLK_I);
      pc_exp++;
   endtask
   task opc(input logic [7:0] op, input logic p2, input logic [2:0] mode, input logic wide, input logic pb);
      if (p2) begin
         send(8'h18);
         chk("prefix pulse", 16'h0, OPCODE_VALID_O);
      end
      send(op);
      BYTE_VALID_I = 1'b0;
      chk("opcode pulse", 16'h1, OPCODE_VALID_O);
      chk("opcode", op, OPCODE_O);
      chk("page two", p2, PAGE2_O);
      OPC_VALID_I = 1'b1;
      OPC_MODE_I = mode;
      OPC_WIDE_I = wide;
      OPC_HAS_POSTBYTE_I = pb;
      @(negedge CLK_I);
      OPC_VALID_I = 1'b0;
   endtask
   task tail(input int n, input logic [15:0] v);
      if (n == 2) send(v[15:8]);
      if (n >= 1) send(v[7:0]);
      BYTE_VALID_I = 1'b0;
   endtask
   // Pointer data held back one cycle so the request has to stand
   task wait_ea(input logic [15:0] exp, input logic [15:0] paddr);
      int n;
      int seen;
      n = 0;
      seen = 0;
      while (EA_VALID_O !== 1'b1 && n < 20) begin
         if (PTR_REQ_O === 1'b1 && seen < 2) begin
            seen++;
            chk("pointer address", paddr, PTR_ADDR_O);
            PTR_DATA_I = exp;
            PTR_VALID_I = (seen == 2);
         end else PTR_VALID_I = 1'b0;
         @(negedge CLK_I);
         n++;
      end
      PTR_VALID_I = 1'b0;
      chk("address pulse", 16'h1, EA_VALID_O);
      chk("address", exp, EA_O);
      chk("illegal pulse", 16'h0, ILLEGAL_O);
   endtask
   // No pulse may show for modes without a memory operand
   task no_ea;
      int k;
      for (k = 0; k < 5; k++) begin
         chk("stray address pulse", 16'h0, EA_VALID_O);
         @(negedge CLK_I);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk("ready", 16'h1, BYTE_READY_O);
      chk("flags", 16'h00D0, CONDITION_FLAGS_O);
      chk("counter", 16'h0, PC_O);
   endtask
   task t_regs;
      wr(7'h40, 16'h0012);
      wr(7'h20, 16'h0034);
      chk("double acc", 16'h1234, ACC_D_O);
      FLAGS_WE_I = 1'b1;
      FLAGS_I = 8'h2B;
      @(negedge CLK_I);
      FLAGS_WE_I = 1'b0;
      @(negedge CLK_I);
      chk("flags", 16'h002B, CONDITION_FLAGS_O);
   endtask
   task t_plain;
      opc(8'h96, 1'b0, `MODE_DIRECT, 1'b0, 1'b0);
      tail(1, 16'h00FF);
      wait_ea(16'h00FF, 16'h0);
      chk("mode", `MODE_DIRECT, MODE_O);
      opc(8'hB6, 1'b0, `MODE_EXTENDED, 1'b0, 1'b0);
      tail(2, 16'hFE01);
      wait_ea(16'hFE01, 16'h0);
      opc(8'hCC, 1'b0, `MODE_IMMEDIATE, 1'b1, 1'b0);
      tail(2, 16'hBEEF);
      no_ea;
      chk("wide operand", 16'hBEEF, IMM_O);
      // Second prefix byte in a row is itself the opcode
      opc(8'h18, 1'b1, `MODE_IMMEDIATE, 1'b0, 1'b0);
      tail(1, 16'h00A5);
      no_ea;
      chk("narrow operand", 16'h00A5, IMM_O);
      opc(8'h87, 1'b0, `MODE_INHERENT, 1'b0, 1'b0);
      no_ea;
   endtask
   task t_rel;
      wr(7'h01, 16'h4000);
      pc_exp = 16'h4000;
      opc(8'h20, 1'b0, `MODE_RELATIVE, 1'b0, 1'b0);
      tail(1, 16'h00F0);
      wait_ea(pc_exp - 16'h0010, 16'h0);
      opc(8'h26, 1'b1, `MODE_RELATIVE, 1'b1, 1'b0);
      tail(2, 16'h0100);
      wait_ea(pc_exp + 16'h0100, 16'h0);
      @(negedge CLK_I);
      chk("counter", pc_exp, PC_O);
   endtask
   task t_idx;
      int i;
      wr(7'h08, 16'h1000);
      wr(7'h04, 16'h2000);
      wr(7'h02, 16'h3000);
      wr(7'h10, 16'h8005);
      for (i = 0; i < 14; i++) begin
         opc(8'hA6, 1'b0, `MODE_INDEXED, 1'b0, 1'b1);
         send(pb_tab[i]);
         tail(nx_tab[i], ex_tab[i]);
         wait_ea(ea_tab[i], pa_tab[i]);
      end
      // Counter as base: points past the postbyte here
      opc(8'hA6, 1'b0, `MODE_INDEXED, 1'b0, 1'b1);
      send(8'hC4);
      tail(0, 16'h0000);
      wait_ea(pc_exp + 16'h0004, 16'h0);
      @(negedge CLK_I);
      @(negedge CLK_I);
      chk("first index", 16'h1003, INDEX_X_O);
      chk("second index", 16'h1FFF, INDEX_Y_O);
      chk("stack", 16'h2FF8, STACK_PTR_O);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {RST_N_I, BYTE_VALID_I, OPC_VALID_I, OPC_WIDE_I, OPC_HAS_POSTBYTE_I, PTR_VALID_I, FLAGS_WE_I} = 7'h00;
      {WR_A_I, WR_B_I, WR_D_I, WR_X_I, WR_Y_I, WR_SP_I, WR_PC_I} = 7'h00;
      {BYTE_I, FLAGS_I, OPC_MODE_I, PTR_DATA_I, WR_DATA_I} = 51'h0;
      n_fail = 0;
      checks = 0;
      pc_exp = 16'h0000;
      repeat (6) @(negedge CLK_I);
      RST_N_I = 1'b1;
      @(negedge CLK_I);
      t_reset;
      t_regs;
      t_plain;
      t_rel;
      t_idx;
      end_sim;
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #100000;
      n_fail++;
      $display("Error watchdog expected finish seen hang");
      end_sim;
   end
endmodule // cpu_indexed_address_decoder_bench
bind cpu_indexed_address_decoder cpu_indexed_address_decoder_checker chk_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .BYTE_VALID_I(BYTE_VALID_I), .BYTE_I(BYTE_I), .BYTE_READY_O(BYTE_READY_O), .PTR_REQ_O(PTR_REQ_O),
   .PTR_ADDR_O(PTR_ADDR_O), .PTR_VALID_I(PTR_VALID_I), .PTR_DATA_I(PTR_DATA_I), .WR_D_I(WR_D_I),
   .WR_PC_I(WR_PC_I), .WR_DATA_I(WR_DATA_I), .FLAGS_WE_I(FLAGS_WE_I), .FLAGS_I(FLAGS_I),
   .OPCODE_VALID_O(OPCODE_VALID_O), .OPCODE_O(OPCODE_O), .EA_VALID_O(EA_VALID_O), .EA_O(EA_O),
   .MODE_O(MODE_O), .ACC_D_O(ACC_D_O), .PC_O(PC_O), .CONDITION_FLAGS_O(CONDITION_FLAGS_O));
